// *** design/count_channel.sv ***
// Purpose: One 8-bit count register with compare and restart.
// Assumes: Pulse is a one-cycle strobe on CLK, already gated.
// Notes:   Match is a registered one-cycle pulse.
`timescale 1ns/10ps
module count_channel #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             ce,
	// Control
	input  wire logic             clr,
	input  wire logic             pulse,
	input  wire logic [WIDTH-1:0] cmp,
	// Status
	output logic      [WIDTH-1:0] count,
	output logic                  match
);

	logic             wrap;
	logic [WIDTH-1:0] next_count;

	// After a match the next pulse restarts from zero, so the period is
	// the modulo value plus one pulses.
	always_comb begin
		next_count = wrap ? '0 : WIDTH'(count + 1'b1);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count <= '0;
			wrap  <= 1'b0;
			match <= 1'b0;
		end else if (ce) begin
			match <= 1'b0;
			if (clr) begin
				count <= '0;
				wrap  <= 1'b0;
			end else if (pulse) begin
				count <= next_count;
				if (next_count == cmp) begin
					match <= 1'b1;
					wrap  <= 1'b1;
				end else begin
					wrap  <= 1'b0;
				end
			end
		end
	end

endmodule : count_channel

// *** design/timer_defs.svh ***
// Purpose: Register offsets, field positions and reset values of the
//          three-channel 8-bit timer/event counter.
// Assumes: Offsets are the byte addresses on the CPU data-memory port.
// Notes:   Only definitions live here.
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_CH2_MODE     12'hF90
`define OFS_TIMER_CTRL   12'hF92
`define OFS_CH2_COUNT    12'hF94
`define OFS_CH2_MODULO   12'hF96
`define OFS_HIGH_MODULO  12'hF98
`define OFS_CH0_MODE     12'hFA0
`define OFS_CH0_OE       12'hFA2
`define OFS_CH0_COUNT    12'hFA4
`define OFS_CH0_MODULO   12'hFA6
`define OFS_CH1_MODE     12'hFA8
`define OFS_CH1_OE       12'hFAA
`define OFS_CH1_COUNT    12'hFAC
`define OFS_CH1_MODULO   12'hFAE

// ****************************************************************
// Field positions
// ****************************************************************
`define MODE_SEL_HI      6
`define MODE_SEL_LO      4
`define MODE_START       3
`define MODE_RUN         2
`define MODE_OP_HI       1
`define MODE_OP_LO       0
`define CTRL_GATE_EN     7
`define CTRL_OE2         3
`define CTRL_USED_MASK   8'h8F

// ****************************************************************
// Reset values and divider
// ****************************************************************
`define MODE_RESET       8'h00
`define CTRL_RESET       8'h00
`define BYTE_RESET       8'h00
`define PRESC_WIDTH      12

`endif

// *** design/timer_event_counter.sv ***
// Purpose: Three-channel 8-bit timer/event counter with gating and PWM.
// Assumes: CLK is the main oscillator; register port is synchronous.
// Notes:   Channel 1 cascade mode is treated as plain timer mode.
`timescale 1ns/10ps
`include "timer_defs.svh"
module timer_event_counter #(
	parameter int NCH = 3
) (
	// Clock, enable and reset
	input  wire logic           CLK,
	input  wire logic           CE,
	input  wire logic           RSTN,
	// Register port
	input  wire timer_pkg::addr_t ADDR,
	input  wire logic           WR,
	input  wire timer_pkg::byte_t WDATA,
	input  wire logic           BIT_WR,
	input  wire logic [2:0]     BIT_SEL,
	input  wire logic           BIT_VAL,
	input  wire logic           RD,
	output timer_pkg::byte_t    RDATA,
	// Interrupt flags
	input  wire logic [NCH-1:0] IRQ_CLR,
	output logic      [NCH-1:0] IRQ_FLAG,
	// Pins and serial link
	input  wire logic [NCH-1:0] EVENT_IN,
	output logic      [NCH-1:0] TIMER_OUT,
	output logic                SERIAL_TIMER
);
	import timer_pkg::*;

	// ****************************************************************
	// Registers and state
	// ****************************************************************
	byte_t                     mode_reg [NCH];
	byte_t                     modulo   [NCH];
	byte_t                     high_modulo;
	byte_t                     ctrl_reg;
	logic   [1:0]              oe01;
	logic   [NCH-1:0]          toggle_ff;
	logic   [NCH-1:0]          start;
	logic   [`PRESC_WIDTH-1:0] presc;
	logic   [NCH-1:0]          sync1;
	logic   [NCH-1:0]          sync2;
	logic   [NCH-1:0]          sync3;
	pwm_phase_e                phase;
	byte_t                     count    [NCH];
	logic   [NCH-1:0]          match;
	logic   [NCH-1:0]          pulse;
	logic   [NCH-1:0]          rise;
	logic   [NCH-1:0]          fall;
	byte_t                     cmp      [NCH];
	logic                      pwm_mode;
	logic                      gate_ok;
	byte_t                     next_rdata;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic div_tick(input logic [`PRESC_WIDTH-1:0] p,
	                                  input int k);
		logic t;
		t = 1'b1;
		for (int i = 0; i < `PRESC_WIDTH; i++) begin
			if (i < k) begin
				t = t & p[i];
			end
		end
		return t;
	endfunction : div_tick

	function automatic logic is_mode(input addr_t a, input int ch);
		logic r;
		r = 1'b0;
		case (ch)
			0: r = (a == `OFS_CH0_MODE);
			1: r = (a == `OFS_CH1_MODE);
			default: r = (a == `OFS_CH2_MODE);
		endcase
		return r;
	endfunction : is_mode

	function automatic logic is_modulo(input addr_t a, input int ch);
		logic r;
		r = 1'b0;
		case (ch)
			0: r = (a == `OFS_CH0_MODULO);
			1: r = (a == `OFS_CH1_MODULO);
			default: r = (a == `OFS_CH2_MODULO);
		endcase
		return r;
	endfunction : is_modulo

	// ****************************************************************
	// Prescaler and event input synchronisers
	// ****************************************************************
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			presc <= '0;
		end else if (CE) begin
			presc <= `PRESC_WIDTH'(presc + 1'b1);
		end
	end

	// The third stage only exists so edge detection never looks at the
	// first synchroniser flop.
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
		end else if (CE) begin
			sync1 <= EVENT_IN;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	assign rise = sync2 & ~sync3;
	assign fall = ~sync2 & sync3;

	// ****************************************************************
	// Count pulse selection
	// ****************************************************************
	assign pwm_mode = (mode_reg[2][`MODE_OP_HI:`MODE_OP_LO] == OP_PWM);
	assign gate_ok  = !ctrl_reg[`CTRL_GATE_EN] || toggle_ff[0];

	always_comb begin
		logic p0;
		logic p1;
		logic p2;
		p0 = 1'b0;
		p1 = 1'b0;
		p2 = 1'b0;
		unique case (mode_reg[0][`MODE_SEL_HI:`MODE_SEL_LO])
			3'b000: p0 = rise[0];
			3'b001: p0 = fall[0];
			3'b100: p0 = div_tick(presc, 10);
			3'b101: p0 = div_tick(presc, 8);
			3'b110: p0 = div_tick(presc, 6);
			3'b111: p0 = div_tick(presc, 4);
			default: p0 = 1'b0;
		endcase
		unique case (mode_reg[1][`MODE_SEL_HI:`MODE_SEL_LO])
			3'b000: p1 = rise[1];
			3'b001: p1 = fall[1];
			3'b010: p1 = match[2];
			3'b011: p1 = div_tick(presc, 5);
			3'b100: p1 = div_tick(presc, 12);
			3'b101: p1 = div_tick(presc, 10);
			3'b110: p1 = div_tick(presc, 8);
			default: p1 = div_tick(presc, 6);
		endcase
		unique case (mode_reg[2][`MODE_SEL_HI:`MODE_SEL_LO])
			3'b000: p2 = rise[2];
			3'b001: p2 = fall[2];
			3'b010: p2 = div_tick(presc, 1);
			3'b011: p2 = 1'b1;
			3'b100: p2 = div_tick(presc, 10);
			3'b101: p2 = div_tick(presc, 8);
			3'b110: p2 = div_tick(presc, 6);
			default: p2 = div_tick(presc, 4);
		endcase
		pulse[0] = p0 && mode_reg[0][`MODE_RUN];
		pulse[1] = p1 && mode_reg[1][`MODE_RUN];
		pulse[2] = p2 && mode_reg[2][`MODE_RUN] && gate_ok;
	end

	always_comb begin
		cmp[0] = modulo[0];
		cmp[1] = modulo[1];
		cmp[2] = (pwm_mode && phase == PH_HIGH) ? high_modulo : modulo[2];
	end

	// ****************************************************************
	// Counters
	// ****************************************************************
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		count_channel #(
			.WIDTH (8)
		) u_chan (
			.clk   (CLK),
			.rstn  (RSTN),
			.ce    (CE),
			.clr   (start[g]),
			.pulse (pulse[g]),
			.cmp   (cmp[g]),
			.count (count[g]),
			.match (match[g])
		);
	end

	// ****************************************************************
	// Register writes
	// ****************************************************************
	// The start bit never stores: it reads back as zero, which is the
	// automatic clear once the timer starts.
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			for (int i = 0; i < NCH; i++) begin
				mode_reg[i] <= `MODE_RESET;
				modulo[i]   <= `BYTE_RESET;
			end
			high_modulo <= `BYTE_RESET;
			ctrl_reg    <= `CTRL_RESET;
			oe01        <= '0;
			start       <= '0;
		end else if (CE) begin
			start <= '0;
			for (int i = 0; i < NCH; i++) begin
				if (WR && is_mode(ADDR, i)) begin
					mode_reg[i] <= WDATA & ~(8'h01 << `MODE_START);
					start[i]    <= WDATA[`MODE_START];
				end
				if (BIT_WR && is_mode(ADDR, i) && BIT_SEL == 3'(`MODE_START)) begin
					start[i] <= BIT_VAL;
				end
				if (WR && is_modulo(ADDR, i)) begin
					modulo[i] <= WDATA;
				end
			end
			if (WR && ADDR == `OFS_HIGH_MODULO) begin
				high_modulo <= WDATA;
			end
			if (WR && ADDR == `OFS_TIMER_CTRL) begin
				ctrl_reg <= WDATA & `CTRL_USED_MASK;
			end
			if (BIT_WR && ADDR == `OFS_TIMER_CTRL) begin
				ctrl_reg[BIT_SEL] <= BIT_VAL & |(`CTRL_USED_MASK & (8'h01 << BIT_SEL));
			end
			if (WR && ADDR == `OFS_CH0_OE) begin
				oe01[0] <= WDATA[0];
			end
			if (WR && ADDR == `OFS_CH1_OE) begin
				oe01[1] <= WDATA[0];
			end
			if (BIT_WR && ADDR == `OFS_CH0_OE && BIT_SEL == 3'd0) begin
				oe01[0] <= BIT_VAL;
			end
			if (BIT_WR && ADDR == `OFS_CH1_OE && BIT_SEL == 3'd0) begin
				oe01[1] <= BIT_VAL;
			end
		end
	end

	// ****************************************************************
	// Interrupt flags, toggle flip-flops and PWM phase
	// ****************************************************************
	// A match in the same cycle as a software clear keeps the flag set.
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			IRQ_FLAG <= '0;
		end else if (CE) begin
			for (int i = 0; i < NCH; i++) begin
				if (start[i] || IRQ_CLR[i]) begin
					IRQ_FLAG[i] <= 1'b0;
				end
				if (match[i] && !(i == 2 && pwm_mode && phase == PH_HIGH)) begin
					IRQ_FLAG[i] <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			toggle_ff <= '0;
		end else if (CE) begin
			for (int i = 0; i < NCH; i++) begin
				if (start[i] && i < 2) begin
					toggle_ff[i] <= 1'b0;
				end else if (start[i] && pwm_mode) begin
					toggle_ff[i] <= 1'b1;
				end else if (match[i]) begin
					toggle_ff[i] <= ~toggle_ff[i];
				end
			end
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			phase <= PH_HIGH;
		end else if (CE) begin
			if (start[2] || !pwm_mode) begin
				phase <= PH_HIGH;
			end else if (match[2]) begin
				phase <= (phase == PH_HIGH) ? PH_LOW : PH_HIGH;
			end
		end
	end

	// ****************************************************************
	// Pins and serial link
	// ****************************************************************
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			TIMER_OUT    <= '0;
			SERIAL_TIMER <= 1'b0;
		end else if (CE) begin
			TIMER_OUT[0] <= oe01[0] & toggle_ff[0];
			TIMER_OUT[1] <= oe01[1] & toggle_ff[1];
			TIMER_OUT[2] <= ctrl_reg[`CTRL_OE2] & toggle_ff[2];
			SERIAL_TIMER <= toggle_ff[0];
		end
	end

	// ****************************************************************
	// Register reads
	// ****************************************************************
	always_comb begin
		next_rdata = 8'h00;
		unique case (ADDR)
			`OFS_CH0_MODE:    next_rdata = mode_reg[0];
			`OFS_CH1_MODE:    next_rdata = mode_reg[1];
			`OFS_CH2_MODE:    next_rdata = mode_reg[2];
			`OFS_CH0_MODULO:  next_rdata = modulo[0];
			`OFS_CH1_MODULO:  next_rdata = modulo[1];
			`OFS_CH2_MODULO:  next_rdata = modulo[2];
			`OFS_CH0_COUNT:   next_rdata = count[0];
			`OFS_CH1_COUNT:   next_rdata = count[1];
			`OFS_CH2_COUNT:   next_rdata = count[2];
			`OFS_HIGH_MODULO: next_rdata = high_modulo;
			`OFS_TIMER_CTRL:  next_rdata = ctrl_reg;
			`OFS_CH0_OE:      next_rdata = {7'h00, oe01[0]};
			`OFS_CH1_OE:      next_rdata = {7'h00, oe01[1]};
			default:          next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			RDATA <= 8'h00;
		end else if (CE && RD) begin
			RDATA <= next_rdata;
		end
	end

endmodule : timer_event_counter

// *** design/timer_pkg.sv ***
// Purpose: Types shared by the timer/event counter files.
// Assumes: Nothing beyond the constants header.
// Notes:   Constants are macros; only types live here.
package timer_pkg;

	typedef logic [7:0] byte_t;
	typedef logic [11:0] addr_t;

	typedef enum logic [1:0] {
		OP_TIMER   = 2'b00,
		OP_PWM     = 2'b01,
		OP_CASCADE = 2'b10,
		OP_SPARE   = 2'b11
	} opmode_e;

	typedef enum logic {
		PH_HIGH = 1'b0,
		PH_LOW  = 1'b1
	} pwm_phase_e;

endpackage : timer_pkg

// *** sim/event_source.sv ***
// Purpose: External event pulse sources on the three event pins.
// Assumes: Pins are driven push-pull by the sources at all times.
// Notes:   Every pin toggles each HALF cycles, so rising edges come every 2*HALF.
`timescale 1ns/10ps
module event_source #(
	parameter int HALF = 5
) (
	// Clock
	input wire logic  clk,
	// Pins
	output logic [2:0] ev
);
	int cnt = 0;

	initial ev = 3'b000;

	always @(posedge clk) begin
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		if (cnt == HALF - 1) ev <= ~ev;
	end
endmodule : event_source

// *** sim/timer_event_counter_props.sv ***
// Purpose: Port-level assertions for the timer/event counter.
// Assumes: CE stays high; enable bits are only written as whole bytes.
// Notes:   Shadows of the enable and run bits follow register writes.
`timescale 1ns/10ps
`include "timer_defs.svh"
module timer_event_counter_props #(
	parameter int NCH = 3
) (
	// Clock, enable and reset
	input wire logic             CLK,
	input wire logic             CE,
	input wire logic             RSTN,
	// Register port
	input wire timer_pkg::addr_t ADDR,
	input wire logic             WR,
	input wire timer_pkg::byte_t WDATA,
	input wire logic             BIT_WR,
	input wire logic [2:0]       BIT_SEL,
	input wire logic             BIT_VAL,
	input wire logic             RD,
	input wire timer_pkg::byte_t RDATA,
	// Flags and pins
	input wire logic [NCH-1:0]   IRQ_CLR,
	input wire logic [NCH-1:0]   IRQ_FLAG,
	input wire logic [NCH-1:0]   EVENT_IN,
	input wire logic [NCH-1:0]   TIMER_OUT,
	input wire logic             SERIAL_TIMER
);
	import timer_pkg::*;

	logic oe0;
	logic oe2;
	logic run2;
	logic st2;

	assign st2 = CE && ADDR == `OFS_CH2_MODE
		&& (WR && WDATA[3] || BIT_WR && BIT_SEL == 3'd3 && BIT_VAL);

	// ****************************************************************
	// Register shadows
	// ****************************************************************
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			oe0 <= 1'b0;
			oe2 <= 1'b0;
			run2 <= 1'b0;
		end else if (CE && WR) begin
			if (ADDR == `OFS_CH0_OE) oe0 <= WDATA[0];
			if (ADDR == `OFS_TIMER_CTRL) oe2 <= WDATA[3];
			if (ADDR == `OFS_CH2_MODE) run2 <= WDATA[2];
		end
	end

	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);

	sequence s_wr_mode;
		CE && WR && !BIT_WR && ADDR == `OFS_CH2_MODE;
	endsequence
	sequence s_rd_mode;
		CE && RD && !WR && !BIT_WR && ADDR == `OFS_CH2_MODE;
	endsequence
	// A stopped counter cannot have a match in flight, so the clear is exact.
	sequence s_idle_start;
		(!run2) [*3] ##0 (st2 && !(WR && WDATA[2]));
	endsequence

	a_unmapped_read: assert property ((RD && CE && ADDR[11:8] != 4'hF)
		|=> RDATA == 8'h00) else $error("unmapped read not zero");
	a_bit3_reads0: assert property (s_rd_mode |=> !RDATA[3])
		else $error("start bit read back as one");
	a_ctrl_spare: assert property ((CE && RD && ADDR == `OFS_TIMER_CTRL)
		|=> RDATA[6:4] == 3'b000) else $error("control spare bits set");
	a_mode_readback: assert property (s_wr_mode ##1 s_rd_mode
		|=> RDATA == ($past(WDATA, 2) & 8'hF7))
		else $error("mode register readback wrong");
	a_start_clears: assert property (s_idle_start
		|-> ##3 !IRQ_FLAG[2]) else $error("start left flag set");
	a_flag_holds: assert property ($fell(IRQ_FLAG[2])
		|-> $past(IRQ_CLR[2]) || $past(st2) || $past(st2, 2)
		|| $past(st2, 3)) else $error("flag fell without cause");
	a_oe_low: assert property (!oe2 [*2] |-> !TIMER_OUT[2])
		else $error("disabled output not low");
	a_serial_same: assert property (oe0 [*2]
		|-> TIMER_OUT[0] == SERIAL_TIMER)
		else $error("serial signal differs from pin");
	a_toggle_flag: assert property ($rose(IRQ_FLAG[0])
		|=> SERIAL_TIMER != $past(SERIAL_TIMER))
		else $error("match did not toggle flop");
endmodule : timer_event_counter_props

bind timer_event_counter timer_event_counter_props #(
	.NCH(NCH)
) timer_event_counter_props_inst (
	.CLK(CLK), .CE(CE), .RSTN(RSTN), .ADDR(ADDR), .WR(WR),
	.WDATA(WDATA), .BIT_WR(BIT_WR), .BIT_SEL(BIT_SEL),
	.BIT_VAL(BIT_VAL), .RD(RD), .RDATA(RDATA), .IRQ_CLR(IRQ_CLR),
	.IRQ_FLAG(IRQ_FLAG), .EVENT_IN(EVENT_IN), .TIMER_OUT(TIMER_OUT),
	.SERIAL_TIMER(SERIAL_TIMER)
);

// *** sim/timer_event_counter_tb.sv ***
// Purpose: Self-checking bench for the timer/event counter.
// Assumes: CE held high; periods are measured between two flag sets.
// Notes:   The first interval after a start is skipped, its phase is free.
`timescale 1ns/10ps
`include "timer_defs.svh"
module timer_event_counter_tb;
	import timer_pkg::*;
	localparam int HALF = 5;
	logic CLK = 1'b0;
	logic CE, RSTN, WR, BIT_WR, BIT_VAL, RD, SERIAL_TIMER;
	logic [2:0] BIT_SEL, IRQ_CLR, IRQ_FLAG, EVENT_IN, TIMER_OUT;
	addr_t ADDR;
	byte_t WDATA, RDATA, d, e;
	int error_cnt = 0;
	int total_checks = 0;
	int p, m, n, c;

	always #5 CLK = ~CLK;

	timer_event_counter timer_event_counter_inst (
		.CLK(CLK), .CE(CE), .RSTN(RSTN), .ADDR(ADDR), .WR(WR),
		.WDATA(WDATA), .BIT_WR(BIT_WR), .BIT_SEL(BIT_SEL),
		.BIT_VAL(BIT_VAL), .RD(RD), .RDATA(RDATA), .IRQ_CLR(IRQ_CLR),
		.IRQ_FLAG(IRQ_FLAG), .EVENT_IN(EVENT_IN), .TIMER_OUT(TIMER_OUT),
		.SERIAL_TIMER(SERIAL_TIMER)
	);
	event_source #(.HALF(HALF)) event_source_inst (.clk(CLK), .ev(EVENT_IN));

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task give_verdict;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : give_verdict
	task chk(input logic [15:0] g, input logic [15:0] x);
		total_checks++;
		if (g !== x) begin
			error_cnt++;
			$display("BAD %0t got %0h expected %0h", $time, g, x);
		end
	endtask : chk
	task fail;
		error_cnt++;
		$display("BAD %0t wait ran out", $time);
		give_verdict();
	endtask : fail
	task step;
		@(posedge CLK);
		#1;
	endtask : step
	task tick(input int k);
		WR = 1'b0;
		RD = 1'b0;
		BIT_WR = 1'b0;
		repeat (k) step();
	endtask : tick
	// Strobes stay up after the edge so that writes can run back to back.
	task wr(input addr_t a, input byte_t v);
		RD = 1'b0;
		BIT_WR = 1'b0;
		ADDR = a;
		WDATA = v;
		WR = 1'b1;
		step();
	endtask : wr
	task rd(input addr_t a, output byte_t v);
		WR = 1'b0;
		BIT_WR = 1'b0;
		ADDR = a;
		RD = 1'b1;
		step();
		RD = 1'b0;
		step();
		v = RDATA;
	endtask : rd
	task per(input int b, output int q);
		int i;
		IRQ_CLR[b] = 1'b1;
		tick(1);
		IRQ_CLR[b] = 1'b0;
		for (i = 0; i < 9000 && IRQ_FLAG[b] !== 1'b1; i++) step();
		if (i == 9000) fail();
		IRQ_CLR[b] = 1'b1;
		step();
		IRQ_CLR[b] = 1'b0;
		q = 1;
		for (i = 0; i < 9000 && IRQ_FLAG[b] !== 1'b1; i++) begin
			step();
			q++;
		end
		if (i == 9000) fail();
	endtask : per
	task wlev(input logic v, output int q);
		for (q = 0; q < 600 && TIMER_OUT[2] !== v; q++) step();
		if (q == 600) fail();
	endtask : wlev
	function automatic int divof(input logic [2:0] s);
		if (s < 3'd2) return 2 * HALF;
		if (s == 3'd2) return 2;
		if (s == 3'd3) return 1;
		return 1 << (18 - 2 * s);
	endfunction : divof

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{CE, RSTN, WR, BIT_WR, BIT_VAL, RD} = 6'b100000;
		{BIT_SEL, IRQ_CLR, ADDR, WDATA} = '0;
		p = $urandom(32'h5af5728c);
		repeat (10) @(posedge CLK);
		#1 RSTN = 1'b1;
		rd(`OFS_CH2_MODE, d);
		chk(d, 0);
		rd(`OFS_TIMER_CTRL, d);
		chk(d, 0);
		$display("end reset values");
		for (c = 0; c < 8; c++) begin
			m = (c == 3) ? 255 : 1 + $urandom % 3;
			wr(`OFS_CH2_MODULO, m[7:0]);
			wr(`OFS_CH2_MODE, {1'b0, c[2:0], 4'hC});
			per(2, p);
			chk(p, (m + 1) * divof(c[2:0]));
		end
		$display("end count sources");
		wr(`OFS_CH2_MODE, 8'h30);
		rd(`OFS_CH2_MODE, e);
		chk(e, 8'h30);
		rd(`OFS_CH2_COUNT, d);
		tick(6);
		rd(`OFS_CH2_COUNT, e);
		chk(e, d);
		ADDR = `OFS_CH2_MODE;
		{BIT_SEL, BIT_VAL, BIT_WR} = 5'b01111;
		step();
		tick(3);
		chk(IRQ_FLAG[2], 0);
		rd(`OFS_CH2_COUNT, d);
		chk(d, 0);
		$display("end stop and start");
		wr(`OFS_TIMER_CTRL, 8'h80);
		wr(`OFS_CH2_MODULO, 8'hFF);
		wr(`OFS_CH2_MODE, 8'h3C);
		tick(40);
		rd(`OFS_CH2_COUNT, d);
		chk(d, 0);
		wr(`OFS_CH0_MODULO, 8'h01);
		wr(`OFS_CH0_MODE, 8'h7C);
		per(0, p);
		chk(p, 32);
		rd(`OFS_CH2_COUNT, d);
		chk(d != 0, 1);
		wr(`OFS_CH0_OE, 8'h01);
		tick(1);
		for (c = 0; c < 80 && SERIAL_TIMER !== 1'b1; c++) step();
		if (c == 80) fail();
		wr(`OFS_CH0_MODE, 8'h7C);
		tick(3);
		chk(SERIAL_TIMER, 0);
		chk(TIMER_OUT[0], 0);
		$display("end gated counting");
		m = 1 + $urandom % 20;
		n = 1 + $urandom % 20;
		wr(`OFS_TIMER_CTRL, 8'h08);
		wr(`OFS_HIGH_MODULO, m[7:0]);
		wr(`OFS_CH2_MODULO, n[7:0]);
		wr(`OFS_CH2_MODE, 8'h3D);
		tick(1);
		wlev(1'b1, p);
		wlev(1'b0, p);
		wlev(1'b1, p);
		wlev(1'b0, p);
		chk(p, m + 1);
		wlev(1'b1, p);
		chk(p, n + 1);
		chk(IRQ_FLAG[2], 1);
		wr(`OFS_TIMER_CTRL, 8'h00);
		tick(3);
		chk(TIMER_OUT[2], 0);
		chk(TIMER_OUT[1], 0);
		$display("end pulse generator");
		wr(12'h123, 8'hFF);
		rd(12'h123, d);
		chk(d, 0);
		wr(`OFS_TIMER_CTRL, 8'hFF);
		rd(`OFS_TIMER_CTRL, d);
		chk(d, 8'h8F);
		chk(IRQ_FLAG[1], 0);
		$display("end refused accesses");
		give_verdict();
	end
endmodule : timer_event_counter_tb
